// ==== logic/config_readback_global_control.sv ====
`include "corner_ctl_defines.svh"

module config_readback_global_control #(
  parameter int FRAME_BITS = `RB_FRAME_BITS,
  parameter int FRAMES = `RB_FRAMES,
  parameter int CELLS = 5
) (
  input wire logic ref_clk, // system clock 20 MHz
  input wire logic sys_rst, // sync reset, active high
  input wire corner_ctl_pkg::cfg_opts_t opts, // stored options
  input wire logic configured, // array configuration complete
  input wire logic request_pin_n, // shared request / float pin
  input wire logic config_shift_clock, // external shift clock
  input wire logic reset_pin_n, // reset input pin
  input wire logic reprogram_in, // reprogram input
  input wire logic float_routed, // routed float source
  input wire logic gsr_routed, // routed set/reset source
  input wire logic capture_sig, // internal capture signal
  input wire logic startup_clk_in, // routed start-up clock
  input wire logic [CELLS-1:0] cell_out, // logic_cell_unit outputs
  input wire logic [FRAME_BITS-3:0] frame_word, // configuration frame
  input wire logic rd_ready, // sink ready for readback bit
  output logic rd_valid, // readback bit valid
  output logic rd_bit, // readback bit
  output logic rd_data_o, // readback pin output
  output logic rd_data_oe, // readback pin enable
  output logic [$clog2(FRAMES)-1:0] frame_idx, // frame being read
  output logic [CELLS-1:0] capture_mem, // captured cell outputs
  output logic readback_busy, // readback active
  output logic global_float_control, // float active high
  output corner_ctl_pkg::float_ctl_t float_ctl, // float effects
  output logic done_oe, // completion output enable
  output logic global_set_reset_n, // set/reset, active low
  output logic config_abort, // configuration abort
  output logic user_out_en, // user outputs enabled
  output logic done_o, // completion level
  output logic osc_clk // oscillator output
);
  // ================================================================
  // input synchronisers
  logic [1:0] req_s, cck_s, rst_s, stc_s;
  logic req_q, cck_q, stc_q;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      req_s <= 2'h3;
      cck_s <= 2'h0;
      rst_s <= 2'h3;
      stc_s <= 2'h0;
      req_q <= 1'b1;
      cck_q <= 1'b0;
      stc_q <= 1'b0;
    end else begin
      req_s <= {req_s[0], request_pin_n};
      cck_s <= {cck_s[0], config_shift_clock};
      rst_s <= {rst_s[0], reset_pin_n};
      stc_s <= {stc_s[0], startup_clk_in};
      req_q <= req_s[1];
      cck_q <= cck_s[1];
      stc_q <= stc_s[1];
    end
  end
  logic cck_rise, req_fall, pin_rb;
  assign cck_rise = cck_s[1] & ~cck_q;
  assign req_fall = req_q & ~req_s[1];
  assign pin_rb = configured & opts.pin_is_readback;

  // ================================================================
  // readback sequencer
  corner_ctl_pkg::rb_state_t st_q;
  logic [$clog2(FRAME_BITS)-1:0] bit_q;
  logic [2:0] lead_q;
  logic [1:0] hi_edges_q;
  logic used_q, allowed;
  assign allowed = (opts.rb_perm == `RB_PERM_ANY) ||
    (opts.rb_perm == `RB_PERM_ONCE && !used_q);

  function automatic logic frame_bit(
    input logic [$clog2(FRAME_BITS)-1:0] idx,
    input logic [FRAME_BITS-3:0] w,
    input logic [CELLS-1:0] cap);
    logic [FRAME_BITS-3:0] body;
    body = w;
    body[CELLS-1:0] = cap;
    if (idx == 0) frame_bit = 1'b0;
    else if (int'(idx) == FRAME_BITS-1) frame_bit = 1'b1;
    else frame_bit = body[idx-1];
  endfunction

  logic buf_in_ready, shift_go;
  assign shift_go = cck_rise && buf_in_ready;
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !pin_rb) begin
      st_q <= corner_ctl_pkg::RB_IDLE;
      bit_q <= '0;
      lead_q <= 3'h0;
      frame_idx <= '0;
      hi_edges_q <= 2'h0;
    end else begin
      if (req_q && cck_rise && hi_edges_q != 2'h3)
        hi_edges_q <= hi_edges_q + 2'h1;
      unique case (st_q)
        corner_ctl_pkg::RB_IDLE, corner_ctl_pkg::RB_DONE: begin
          if (req_fall && allowed &&
              (st_q == corner_ctl_pkg::RB_IDLE ||
               hi_edges_q >= 2'(`RB_RESTART_EDGES))) begin
            st_q <= corner_ctl_pkg::RB_LEAD;
            lead_q <= 3'h0;
            frame_idx <= '0;
            bit_q <= '0;
          end
        end
        corner_ctl_pkg::RB_LEAD: begin
          if (req_q) st_q <= corner_ctl_pkg::RB_DONE;
          else if (cck_rise) begin
            lead_q <= lead_q + 3'h1;
            if (lead_q == 3'(`RB_LEAD_EDGES - 1))
              st_q <= corner_ctl_pkg::RB_SHIFT;
          end
        end
        corner_ctl_pkg::RB_SHIFT: begin
          if (req_q) st_q <= corner_ctl_pkg::RB_DONE;
          else if (shift_go) begin
            if (int'(bit_q) == FRAME_BITS-1) begin
              bit_q <= '0;
              if (int'(frame_idx) == FRAMES-1)
                st_q <= corner_ctl_pkg::RB_LOCK;
              else frame_idx <= frame_idx + 1'b1;
            end else bit_q <= bit_q + 1'b1;
          end
        end
        corner_ctl_pkg::RB_LOCK: begin
          if (req_q) st_q <= corner_ctl_pkg::RB_DONE;
        end
        default: st_q <= corner_ctl_pkg::RB_IDLE;
      endcase
      if (!req_q) hi_edges_q <= 2'h0;
    end
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst || !configured) used_q <= 1'b0;
    else if (st_q == corner_ctl_pkg::RB_LOCK) used_q <= 1'b1;
  end

  always_ff @(posedge ref_clk) begin
    if (sys_rst) readback_busy <= 1'b0;
    else readback_busy <= pin_rb && (st_q == corner_ctl_pkg::RB_LEAD ||
      st_q == corner_ctl_pkg::RB_SHIFT);
  end

  // ================================================================
  // capture of cell outputs
  logic entry;
  assign entry = req_fall && allowed && pin_rb;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) capture_mem <= '0;
    else if (((opts.cap_mode == `CAP_ENTRY ||
               opts.cap_mode == `CAP_EITHER) && entry) ||
             ((opts.cap_mode == `CAP_SIGNAL ||
               opts.cap_mode == `CAP_EITHER) && !capture_sig))
      capture_mem <= cell_out;
  end

  // ================================================================
  // two-entry buffer in the data path
  logic [1:0] buf_d_q;
  logic [1:0] cnt_q;
  logic push, pop;
  assign buf_in_ready = cnt_q != 2'h2;
  assign push = st_q == corner_ctl_pkg::RB_SHIFT && !req_q && shift_go;
  assign pop = rd_valid && rd_ready;
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !pin_rb) begin
      cnt_q <= 2'h0;
      buf_d_q <= 2'h0;
    end else begin
      cnt_q <= cnt_q + 2'(push) - 2'(pop);
      if (pop) buf_d_q[0] <= buf_d_q[1];
      if (push) begin
        if (cnt_q == 2'h0 || (cnt_q == 2'h1 && pop))
          buf_d_q[0] <= frame_bit(bit_q, frame_word, capture_mem);
        else buf_d_q[1] <= frame_bit(bit_q, frame_word, capture_mem);
      end
    end
  end
  always_comb rd_valid = cnt_q != 2'h0;
  always_comb rd_bit = buf_d_q[0];
  always_ff @(posedge ref_clk) begin
    if (sys_rst) rd_data_o <= 1'b1;
    else if (push) rd_data_o <= frame_bit(bit_q, frame_word, capture_mem);
  end

  // ================================================================
  // global float control
  logic float_n;
  always_comb begin
    if (!configured) float_n = req_q;
    else begin
      unique case (opts.float_src)
        `SRC_PIN: float_n = opts.pin_is_readback ? 1'b1 : req_q;
        `SRC_ROUTED: float_n = ~float_routed;
        default: float_n = 1'b1;
      endcase
      if (opts.float_src != `SRC_OFF && opts.float_invert)
        float_n = ~float_n;
    end
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      global_float_control <= 1'b0;
      float_ctl <= '0;
      rd_data_oe <= 1'b0;
      done_oe <= 1'b0;
    end else begin
      global_float_control <= ~float_n;
      float_ctl <= {4{~float_n}};
      rd_data_oe <= float_n && pin_rb &&
        st_q == corner_ctl_pkg::RB_SHIFT;
      done_oe <= float_n && done_o;
    end
  end

  // ================================================================
  // oscillator
  logic [3:0] osc_cnt_q;
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      osc_cnt_q <= 4'h0;
      osc_clk <= 1'b0;
    end else if (osc_cnt_q == 4'(opts.osc_fast ? `OSC_FAST_HALF - 1
                                            : `OSC_SLOW_HALF - 1)) begin
      osc_cnt_q <= 4'h0;
      osc_clk <= ~osc_clk;
    end else osc_cnt_q <= osc_cnt_q + 4'h1;
  end

  // ================================================================
  // set/reset, abort, start-up
  logic [1:0] su_q;
  logic su_tick, gsr_act;
  assign su_tick = opts.startup_routed_clk ? (stc_s[1] & ~stc_q)
                                           : cck_rise;
  always_comb begin
    unique case (opts.gsr_src)
      `SRC_PIN: gsr_act = ~rst_s[1];
      `SRC_ROUTED: gsr_act = gsr_routed;
      default: gsr_act = 1'b0;
    endcase
    if (opts.gsr_src != `SRC_OFF && opts.gsr_invert)
      gsr_act = ~gsr_act;
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst || !configured || reprogram_in) su_q <= 2'h0;
    else if (su_tick && su_q != 2'(`STARTUP_EDGES)) su_q <= su_q + 2'h1;
  end
  always_ff @(posedge ref_clk) begin
    if (sys_rst) begin
      global_set_reset_n <= 1'b0;
      user_out_en <= 1'b0;
      done_o <= 1'b0;
      config_abort <= 1'b0;
    end else begin
      // each user flop picks its own set or reset value
      global_set_reset_n <= !(su_q < 2'h1 || gsr_act || !configured);
      user_out_en <= su_q >= 2'h2;
      done_o <= su_q >= 2'h3;
      config_abort <= !configured && !rst_s[1];
    end
  end

  // ================================================================
  // checks
  a_no_rb_unconf: assert property (@(posedge ref_clk) disable iff
    (sys_rst) !configured |=> !readback_busy)
    else $error("readback active while unconfigured");
  a_perm_none: assert property (@(posedge ref_clk) disable iff (sys_rst)
    opts.rb_perm == `RB_PERM_NONE && $stable(opts) |-> ##1 !push)
    else $error("readback despite prohibit");
  a_start_low: assert property (@(posedge ref_clk) disable iff (sys_rst)
    push && bit_q == 0 |=> rd_data_o == 1'b0)
    else $error("start bit not low");
  a_stop_high: assert property (@(posedge ref_clk) disable iff (sys_rst)
    push && int'(bit_q) == FRAME_BITS-1 |=> rd_data_o)
    else $error("stop bit not high");
  a_one_per_edge: assert property (@(posedge ref_clk) disable iff
    (sys_rst) $changed(rd_data_o) |-> $past(cck_rise))
    else $error("shift without clock edge");
  a_abort_reset: assert property (@(posedge ref_clk) disable iff
    (sys_rst) !configured && !rst_s[1] |=> config_abort)
    else $error("abort missing");
  a_gsr_unconf: assert property (@(posedge ref_clk) disable iff
    (sys_rst) !configured |=> !global_set_reset_n)
    else $error("set/reset not forced");
  a_float_unconf: assert property (@(posedge ref_clk) disable iff
    (sys_rst) !configured && !req_q |=> global_float_control)
    else $error("float not active low");
  c_readback: cover property (@(posedge ref_clk)
    st_q == corner_ctl_pkg::RB_LOCK);
  c_restart: cover property (@(posedge ref_clk)
    st_q == corner_ctl_pkg::RB_DONE ##[1:400] st_q == corner_ctl_pkg::RB_LEAD);
  c_stall: cover property (@(posedge ref_clk) cnt_q == 2'h2);
endmodule // config_readback_global_control

// ==== logic/corner_ctl_defines.svh ====
`ifndef CORNER_CTL_DEFINES_SVH
`define CORNER_CTL_DEFINES_SVH
// ==================================================================
// readback permission codes
`define RB_PERM_NONE 2'h0
`define RB_PERM_ONCE 2'h1
`define RB_PERM_ANY 2'h2
// capture choices
`define CAP_NONE 2'h0
`define CAP_ENTRY 2'h1
`define CAP_SIGNAL 2'h2
`define CAP_EITHER 2'h3
// float and set/reset source selects
`define SRC_OFF 2'h0
`define SRC_PIN 2'h1
`define SRC_ROUTED 2'h2
// ==================================================================
// timing
`define CLK_HZ 20000000
`define OSC_SLOW_HZ 1250000
`define OSC_FAST_HZ 10000000
`define OSC_SLOW_HALF (`CLK_HZ / (2 * `OSC_SLOW_HZ))
`define OSC_FAST_HALF (`CLK_HZ / (2 * `OSC_FAST_HZ))
`define RB_LEAD_EDGES 4
`define RB_RESTART_EDGES 2
`define RB_FRAME_BITS 16
`define RB_FRAMES 4
`define STARTUP_EDGES 3
`endif

// ==== logic/corner_ctl_pkg.sv ====
package corner_ctl_pkg;
  typedef enum logic [2:0] {
    RB_IDLE = 3'h0,
    RB_LEAD = 3'h1,
    RB_SHIFT = 3'h3,
    RB_DONE = 3'h2,
    RB_LOCK = 3'h6
  } rb_state_t;

  typedef struct packed {
    logic [1:0] rb_perm;
    logic pin_is_readback;
    logic [1:0] cap_mode;
    logic [1:0] float_src;
    logic float_invert;
    logic [1:0] gsr_src;
    logic gsr_invert;
    logic osc_fast;
    logic startup_routed_clk;
  } cfg_opts_t;

  typedef struct packed {
    logic out_float;
    logic in_pullup;
    logic in_pulldown_off;
    logic in_ttl;
  } float_ctl_t;
endpackage

// ==== test/readback_host.sv ====
// ==================================================================
// host side: request pin, shift clock and a stalling bit sink
module readback_host (
  input wire logic ref_clk, // system clock
  input wire logic rd_valid, // bit offered by the block
  input wire logic rd_bit, // offered bit
  output logic rd_ready, // sink takes the bit
  output logic request_pin_n, // shared request pin
  output logic config_shift_clock // link clock, still between shift calls
);
  timeunit 1ns;
  timeprecision 1ns;
  logic slow;
  logic [3:0] cnt_q;
  logic bits_q[$];
  initial begin
    slow = 1'b0;
    cnt_q = 4'h0;
    request_pin_n = 1'b1;
    config_shift_clock = 1'b0;
    rd_ready = 1'b0;
  end
  // stall six cycles in sixteen when slow
  always @(posedge ref_clk) begin
    cnt_q <= cnt_q + 4'h1;
    rd_ready <= !(slow && cnt_q >= 4'hA);
    if (rd_valid === 1'b1 && rd_ready)
      bits_q.push_back(rd_bit);
  end
  // pin held at its level until the next call
  task automatic request(input logic lvl);
    @(posedge ref_clk);
    request_pin_n <= lvl;
  endtask
  // 400 ns period, offset from the system clock
  task automatic shift(input int n);
    #7;
    repeat (n) begin
      #200 config_shift_clock = 1'b1;
      #200 config_shift_clock = 1'b0;
    end
  endtask
  task automatic restart();
    request(1'b1);
    shift(2);
    request(1'b0);
  endtask
endmodule // readback_host

// ==== test/config_readback_global_control_tb.sv ====
`include "corner_ctl_defines.svh"
module config_readback_global_control_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [13:0] WORD = 14'h2A5C;
  localparam logic [15:0] USED = 16'hFFFF;
  localparam logic [4:0] CAPS [4] = '{5'h00, 5'h15, 5'h0A, 5'h1F};
  logic ref_clk, sys_rst, configured, reset_pin_n, float_routed;
  logic capture_sig, rd_ready, rd_valid, rd_bit, request_pin_n;
  logic config_shift_clock, rd_data_oe, global_float_control, done_oe;
  logic global_set_reset_n, config_abort, user_out_en, done_o, osc_clk;
  logic [4:0] cell_out;
  logic [4:0] capture_mem;
  logic [1:0] frame_idx;
  logic reprogram_in, gsr_routed, rd_data_o, readback_busy;
  corner_ctl_pkg::cfg_opts_t cfg;
  corner_ctl_pkg::float_ctl_t float_ctl;
  int n_fail, comparisons;
  config_readback_global_control i_config_readback_global_control (
    .ref_clk(ref_clk), .sys_rst(sys_rst), .opts(cfg),
    .configured(configured), .request_pin_n(request_pin_n),
    .config_shift_clock(config_shift_clock), .reset_pin_n(reset_pin_n),
    .reprogram_in(reprogram_in), .float_routed(float_routed),
    .gsr_routed(gsr_routed), .capture_sig(capture_sig),
    .startup_clk_in(1'b0), .cell_out(cell_out),
    .frame_word(WORD), .rd_ready(rd_ready), .rd_valid(rd_valid),
    .rd_bit(rd_bit), .rd_data_o(rd_data_o), .rd_data_oe(rd_data_oe),
    .frame_idx(frame_idx), .capture_mem(capture_mem),
    .readback_busy(readback_busy),
    .global_float_control(global_float_control), .float_ctl(float_ctl),
    .done_oe(done_oe), .global_set_reset_n(global_set_reset_n),
    .config_abort(config_abort), .user_out_en(user_out_en),
    .done_o(done_o), .osc_clk(osc_clk));
  readback_host i_readback_host (.ref_clk(ref_clk), .rd_valid(rd_valid),
    .rd_bit(rd_bit), .rd_ready(rd_ready), .request_pin_n(request_pin_n),
    .config_shift_clock(config_shift_clock));
  initial begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end
  // ==================================================================
  // checking helpers
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d n_fail %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  function automatic logic [15:0] frame(input logic [4:0] cap);
    return {1'b1, WORD[13:5], cap, 1'b0};
  endfunction
  task automatic run(input int n);
    i_readback_host.bits_q.delete();
    i_readback_host.shift(n);
    repeat (16) @(posedge ref_clk);
  endtask
  task automatic read_chk(input logic [15:0] exp);
    logic [15:0] got;
    run(20);
    got = 'x;
    foreach (i_readback_host.bits_q[i])
      got[i] = i_readback_host.bits_q[i];
    chk(16'(i_readback_host.bits_q.size()), 16'h0010);
    chk(got & USED, exp & USED);
  endtask
  task automatic flt(input logic [1:0] s, input logic v, input logic p,
    input logic r, input logic e);
    @(posedge ref_clk) cfg.float_src <= s;
    @(posedge ref_clk) cfg.float_invert <= v;
    @(posedge ref_clk) float_routed <= r;
    i_readback_host.request(p);
    repeat (6) @(posedge ref_clk);
    chk(global_float_control, e);
    chk(float_ctl, {4{e}});
  endtask
  task automatic osc(input logic fast, input int e);
    int n;
    logic prev;
    n = 0;
    @(posedge ref_clk) cfg.osc_fast <= fast;
    repeat (40) @(posedge ref_clk);
    prev = osc_clk;
    repeat (80) begin
      @(posedge ref_clk);
      #1;
      if (osc_clk === 1'b1 && prev === 1'b0)
        n++;
      prev = osc_clk;
    end
    chk(16'(n >= e - 1 && n <= e + 1), 16'h0001);
  endtask
  // ==================================================================
  // scenarios
  initial begin
    repeat (20000) @(posedge ref_clk);
    n_fail++;
    end_of_test();
  end
  initial begin
    n_fail = 0;
    comparisons = 0;
    sys_rst = 1'b1;
    configured = 1'b0;
    reset_pin_n = 1'b1;
    float_routed = 1'b0;
    reprogram_in = 1'b0;
    gsr_routed = 1'b0;
    capture_sig = 1'b1;
    cell_out = 5'h1B;
    cfg = '0;
    cfg.rb_perm = `RB_PERM_ANY;
    cfg.pin_is_readback = 1'b1;
    repeat (16) @(posedge ref_clk);
    sys_rst <= 1'b0;
    repeat (3) @(posedge ref_clk);
    i_readback_host.request(1'b0);
    @(posedge ref_clk) reset_pin_n <= 1'b0;
    run(20);
    chk(16'(i_readback_host.bits_q.size()), 16'h0000);
    chk(global_float_control, 1'b1);
    chk(float_ctl, 4'hF);
    chk({rd_data_oe, done_oe}, 2'h0);
    chk(global_set_reset_n, 1'b0);
    chk(config_abort, 1'b1);
    i_readback_host.request(1'b1);
    @(posedge ref_clk) reset_pin_n <= 1'b1;
    @(posedge ref_clk) configured <= 1'b1;
    run(6);
    chk({global_set_reset_n, user_out_en, done_o}, 3'h7);
    @(posedge ref_clk) reprogram_in <= 1'b1;
    repeat (3) @(posedge ref_clk);
    chk({global_set_reset_n, user_out_en, done_o}, 3'h0);
    @(posedge ref_clk) reprogram_in <= 1'b0;
    run(6);
    chk({global_set_reset_n, user_out_en, done_o}, 3'h7);
    chk(global_float_control, 1'b0);
    @(posedge ref_clk) cfg.gsr_src <= `SRC_PIN;
    @(posedge ref_clk) reset_pin_n <= 1'b0;
    repeat (6) @(posedge ref_clk);
    chk(global_set_reset_n, 1'b0);
    @(posedge ref_clk) cfg.gsr_invert <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk(global_set_reset_n, 1'b1);
    @(posedge ref_clk) cfg.gsr_src <= `SRC_ROUTED;
    repeat (6) @(posedge ref_clk);
    chk(global_set_reset_n, 1'b0);
    @(posedge ref_clk) gsr_routed <= 1'b1;
    repeat (6) @(posedge ref_clk);
    chk(global_set_reset_n, 1'b1);
    @(posedge ref_clk) cfg.gsr_src <= `SRC_OFF;
    i_readback_host.slow <= 1'b1;
    i_readback_host.request(1'b0);
    read_chk(frame(5'h00));
    chk({readback_busy, frame_idx}, 3'h5);
    chk(rd_data_oe, 1'b1);
    chk(rd_data_o, 1'b1);
    chk(global_float_control, 1'b0);
    i_readback_host.slow <= 1'b0;
    i_readback_host.restart();
    read_chk(frame(5'h00));
    chk(frame_idx, 2'h1);
    for (int m = 0; m < 4; m++) begin
      @(posedge ref_clk) cfg.cap_mode <= m[1:0];
      @(posedge ref_clk) cell_out <= (m == 0) ? 5'h1B : CAPS[m];
      @(posedge ref_clk) capture_sig <= (m != 2);
      i_readback_host.restart();
      read_chk(frame(CAPS[m]));
      chk(capture_mem, CAPS[m]);
    end
    @(posedge ref_clk) cfg.rb_perm <= `RB_PERM_NONE;
    i_readback_host.restart();
    run(20);
    chk(16'(i_readback_host.bits_q.size()), 16'h0000);
    @(posedge ref_clk) cfg.rb_perm <= `RB_PERM_ONCE;
    i_readback_host.restart();
    run(68);
    chk(16'(i_readback_host.bits_q.size()), 16'h0040);
    i_readback_host.restart();
    run(20);
    chk(16'(i_readback_host.bits_q.size()), 16'h0000);
    @(posedge ref_clk) cfg.pin_is_readback <= 1'b0;
    flt(`SRC_PIN, 1'b0, 1'b0, 1'b0, 1'b1);
    flt(`SRC_PIN, 1'b1, 1'b0, 1'b0, 1'b0);
    flt(`SRC_ROUTED, 1'b0, 1'b1, 1'b1, 1'b1);
    flt(`SRC_OFF, 1'b0, 1'b0, 1'b1, 1'b0);
    osc(1'b1, 40);
    osc(1'b0, 5);
    end_of_test();
  end
endmodule // config_readback_global_control_tb
